// File: hdl/ccr_axil_slave.sv
// AXI4-Lite slave turning bus transfers into register strobes.
// Assumes the register file answers reads and write errors combinationally.
`timescale 1ns/100ps
module ccr_axil_slave
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  ccr_reg_if.bus           regPort
);
  logic        awHeld_reg;
  logic        wHeld_reg;
  logic [11:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;

  // One write at a time: no new address or data until the response drains
  assign awready        = !awHeld_reg && !bvalid;
  assign wready         = !wHeld_reg && !bvalid;
  assign regPort.wrEn   = awHeld_reg && wHeld_reg && !bvalid;
  assign regPort.wrAddr = awAddr_reg;
  assign regPort.wrData = wData_reg;
  assign regPort.wrStrb = wStrb_reg;
  assign arready        = !rvalid;
  assign regPort.rdAddr = araddr;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 12'h000;
    end
    else if (awvalid && awready)
    begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= awaddr;
    end
    else if (regPort.wrEn)
      awHeld_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wHeld_reg <= 1'b1;
      wData_reg <= wdata;
      wStrb_reg <= wstrb;
    end
    else if (regPort.wrEn)
      wHeld_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bvalid <= 1'b0;
      bresp  <= ccr_pkg::RESP_OKAY;
    end
    else if (regPort.wrEn)
    begin
      bvalid <= 1'b1;
      bresp  <= regPort.wrErr ? ccr_pkg::RESP_SLVERR : ccr_pkg::RESP_OKAY;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= ccr_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= regPort.rdData;
      rresp  <= regPort.rdErr ? ccr_pkg::RESP_SLVERR : ccr_pkg::RESP_OKAY;
    end
    else if (rready)
      rvalid <= 1'b0;
  end
endmodule

// File: hdl/ccr_pkg.sv
// Constants for the clock control register block.
// Assumes a 32-bit register bus with 12-bit byte offsets.
// Summary of operation
// - Writing one to enable-set bits 0..3 enables the four event interrupts.
// - Fast start-seen bit 0 reads one once the fast start task fired.
// - Slow start-seen bit 0 reads one once the slow start task fired.
// - Slow start task captures the source selection into a read-only snapshot.
// - Snapshot source encodes 0 for RC oscillator and 1 for crystal.
// - Source select bits 1:0 encode 0 RC, 1 crystal, 2 synthesized.
// - Bypass bit one selects rail-to-rail external clock bypassing the crystal.
// - External bit zero keeps crystal, one switches to an external source.
// - Calibration interval period equals field value times a quarter second.
// - Calibration interval field is seven bits, valid values 1 to 127.
// - Calibration interval keeps its value across low-power resets.
// - Bypass bit zero means crystal or low-swing external source use.
// - Set/clear enable writes of one act, zero ignored, reads show enables.
// - Event flags stay set until software writes zero to them or a one to the summary register.
package ccr_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          NUM_EVT         = 4;
  localparam logic [11:0] OFS_EVT_FAST    = 12'h100;
  localparam logic [11:0] OFS_EVT_SLOW    = 12'h104;
  localparam logic [11:0] OFS_EVT_DONE    = 12'h10c;
  localparam logic [11:0] OFS_EVT_TMO     = 12'h110;
  localparam logic [11:0] OFS_IRQ_SET     = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR     = 12'h308;
  localparam logic [11:0] OFS_FAST_SEEN   = 12'h408;
  localparam logic [11:0] OFS_FAST_STATE  = 12'h40c;
  localparam logic [11:0] OFS_SLOW_SEEN   = 12'h414;
  localparam logic [11:0] OFS_SLOW_STATE  = 12'h418;
  localparam logic [11:0] OFS_SLOW_SNAP   = 12'h41c;
  localparam logic [11:0] OFS_SLOW_SEL    = 12'h518;
  localparam logic [11:0] OFS_CAL_IV      = 12'h538;
  localparam logic [11:0] OFS_IRQ_STATUS  = 12'h600;
  localparam int          POS_RUNNING     = 16;
  localparam int          POS_BYPASS      = 16;
  localparam int          POS_EXTERNAL    = 17;
  localparam int          SRC_W           = 2;
  localparam int          CAL_W           = 7;
  localparam int          CAL_UNIT_MS     = 250;
  localparam int          CAL_PERIOD_W    = 15;
  localparam logic [1:0]  SRC_RC          = 2'h0;
  localparam logic [1:0]  SRC_XTAL        = 2'h1;
  localparam logic [1:0]  SRC_SYNTH       = 2'h2;
  localparam logic [3:0]  IRQ_EN_RESET    = 4'h0;
  localparam logic [1:0]  SRC_RESET       = 2'h0;
  localparam logic [6:0]  CAL_RESET       = 7'h00;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// File: hdl/ccr_reg_if.sv
// Internal register access port between bus slave and register file.
// Assumes both ends sit on sys_clk.
`timescale 1ns/100ps
interface ccr_reg_if;
  logic        wrEn;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        wrErr;
  logic [11:0] rdAddr;
  logic [31:0] rdData;
  logic        rdErr;
  modport bus
  (
    output wrEn, wrAddr, wrData, wrStrb, rdAddr,
    input  wrErr, rdData, rdErr
  );
  modport regs
  (
    input  wrEn, wrAddr, wrData, wrStrb, rdAddr,
    output wrErr, rdData, rdErr
  );
endinterface

// File: hdl/ccr_top.sv
// Clock control register block: enables, start status, source select.
// Assumes task and event strobes are one-cycle pulses on sys_clk;
// oscillator status levels arrive asynchronously from the analog side.
`timescale 1ns/100ps
module ccr_top
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        retRst_n,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  input  wire logic        fastStartTask,
  input  wire logic        slowStartTask,
  input  wire logic        fastStartedEvt,
  input  wire logic        slowStartedEvt,
  input  wire logic        calDoneEvt,
  input  wire logic        calTimeoutEvt,
  input  wire logic        fastRunning,
  input  wire logic        fastXtalActive,
  input  wire logic        slowRunning,
  output      logic [1:0]  slowSourceSel,
  output      logic        slowBypass,
  output      logic        slowExternal,
  output      logic [1:0]  slowSourceSnap,
  output      logic [6:0]  calInterval,
  output      logic [14:0] calPeriodMs,
  output      logic        irq
);
  ccr_reg_if regPort ();

  ccr_axil_slave i_ccr_axil_slave
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .regPort (regPort.bus)
  );

  // Byte lanes to a bit mask, so partial writes touch only their lanes
  function automatic logic [31:0] laneMask(input logic [3:0] strb);
    laneMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Offset of the event register for a given event index
  function automatic logic [11:0] evtOfs(input int idx);
    case (idx)
      0:       evtOfs = ccr_pkg::OFS_EVT_FAST;
      1:       evtOfs = ccr_pkg::OFS_EVT_SLOW;
      2:       evtOfs = ccr_pkg::OFS_EVT_DONE;
      default: evtOfs = ccr_pkg::OFS_EVT_TMO;
    endcase
  endfunction

  // Every decoded offset; anything else answers with an error
  function automatic logic isMapped(input logic [11:0] a);
    case (a)
      ccr_pkg::OFS_EVT_FAST,
      ccr_pkg::OFS_EVT_SLOW,
      ccr_pkg::OFS_EVT_DONE,
      ccr_pkg::OFS_EVT_TMO,
      ccr_pkg::OFS_IRQ_SET,
      ccr_pkg::OFS_IRQ_CLR,
      ccr_pkg::OFS_FAST_SEEN,
      ccr_pkg::OFS_FAST_STATE,
      ccr_pkg::OFS_SLOW_SEEN,
      ccr_pkg::OFS_SLOW_STATE,
      ccr_pkg::OFS_SLOW_SNAP,
      ccr_pkg::OFS_SLOW_SEL,
      ccr_pkg::OFS_CAL_IV,
      ccr_pkg::OFS_IRQ_STATUS: isMapped = 1'b1;
      default:                 isMapped = 1'b0;
    endcase
  endfunction

  // Write strobe for one offset, shared by every writable register below
  function automatic logic wrHit(input logic en, input logic [11:0] a, input logic [11:0] ofs);
    wrHit = en && (a == ofs);
  endfunction

  logic [31:0] wrMasked;
  logic [31:0] wrMask;
  logic        wrIrqSet;
  logic        wrIrqClr;
  logic        wrStatus;
  logic        wrSlowSel;
  logic        wrCalIv;
  logic [3:0]  evtIn;
  logic [3:0]  evtFlag_reg;
  logic [3:0]  irqEn_reg;
  logic [3:0]  pending;
  logic        fastSeen_reg;
  logic        slowSeen_reg;
  logic [1:0]  srcSel_reg;
  logic        bypass_reg;
  logic        external_reg;
  logic [1:0]  srcSnap_reg;
  logic [6:0]  calIv_reg;
  logic [14:0] calPeriod_reg;
  logic [14:0] calPeriod_next;
  logic [2:0]  meta_reg;
  logic [2:0]  stable_reg;
  logic        fastRunSync;
  logic        fastXtalSync;
  logic        slowRunSync;
  logic        rdHole;
  logic        wrHole;
  logic [31:0] rdValue;

  assign wrMask    = laneMask(regPort.wrStrb);
  assign wrMasked  = regPort.wrData & wrMask;
  assign evtIn     = {calTimeoutEvt, calDoneEvt, slowStartedEvt, fastStartedEvt};

  // One strobe per writable offset
  assign wrIrqSet  = wrHit(regPort.wrEn, regPort.wrAddr, ccr_pkg::OFS_IRQ_SET);
  assign wrIrqClr  = wrHit(regPort.wrEn, regPort.wrAddr, ccr_pkg::OFS_IRQ_CLR);
  assign wrStatus  = wrHit(regPort.wrEn, regPort.wrAddr, ccr_pkg::OFS_IRQ_STATUS);
  assign wrSlowSel = wrHit(regPort.wrEn, regPort.wrAddr, ccr_pkg::OFS_SLOW_SEL);
  assign wrCalIv   = wrHit(regPort.wrEn, regPort.wrAddr, ccr_pkg::OFS_CAL_IV);

  // Oscillator status comes from another clock world; two stages first
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg   <= 3'h0;
      stable_reg <= 3'h0;
    end
    else
    begin
      meta_reg   <= {slowRunning, fastXtalActive, fastRunning};
      stable_reg <= meta_reg;
    end
  end

  // Named taps of the second stage; nothing reads the first
  assign fastRunSync  = stable_reg[0];
  assign fastXtalSync = stable_reg[1];
  assign slowRunSync  = stable_reg[2];

  // Flag clears by zero at its own offset or one in the summary register;
  // a new event in the same cycle wins so it is never lost
  genvar gi;
  generate
    for (gi = 0; gi < ccr_pkg::NUM_EVT; gi++)
    begin : g_evt
      logic clrByZero;
      logic clrByOne;
      logic clrHit;
      assign clrByZero = wrHit(regPort.wrEn, regPort.wrAddr, evtOfs(gi)) && wrMask[0] && !regPort.wrData[0];
      assign clrByOne  = wrStatus && wrMasked[gi];
      assign clrHit    = clrByZero || clrByOne;
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
          evtFlag_reg[gi] <= 1'b0;
        else if (evtIn[gi])
          evtFlag_reg[gi] <= 1'b1;
        else if (clrHit)
          evtFlag_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // Set register ors ones in, clear register knocks ones out
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irqEn_reg <= ccr_pkg::IRQ_EN_RESET;
    else if (wrIrqSet)
      irqEn_reg <= irqEn_reg | wrMasked[3:0];
    else if (wrIrqClr)
      irqEn_reg <= irqEn_reg & ~wrMasked[3:0];
  end

  // Pending sources; the output is registered, so it trails by a cycle
  assign pending = evtFlag_reg & irqEn_reg;

  // Level output, drops one cycle after the flag or its enable goes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |pending;
  end

  // Start-seen bits stick; no stop path lives in this block
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fastSeen_reg <= 1'b0;
    else if (fastStartTask)
      fastSeen_reg <= 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      slowSeen_reg <= 1'b0;
    else if (slowStartTask)
      slowSeen_reg <= 1'b1;
  end

  // Snapshot taken from the value standing before any same-cycle write
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      srcSnap_reg <= ccr_pkg::SRC_RESET;
    else if (slowStartTask)
      srcSnap_reg <= srcSel_reg;
  end

  // Source select; the crystal-with-external pairing is left to software,
  // the hardware stores what it is given
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      srcSel_reg <= ccr_pkg::SRC_RESET;
    else if (wrSlowSel && wrMask[0])
      srcSel_reg <= regPort.wrData[ccr_pkg::SRC_W-1:0];
  end

  // Bypass only sets the swing the crystal pins expect
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      bypass_reg <= 1'b0;
    else if (wrSlowSel && wrMask[ccr_pkg::POS_BYPASS])
      bypass_reg <= regPort.wrData[ccr_pkg::POS_BYPASS];
  end

  // External clock stands in for the crystal, so it needs source crystal
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      external_reg <= 1'b0;
    else if (wrSlowSel && wrMask[ccr_pkg::POS_EXTERNAL])
      external_reg <= regPort.wrData[ccr_pkg::POS_EXTERNAL];
  end

  // Retained: only the retention reset clears it, not the system reset
  always_ff @(posedge sys_clk or negedge retRst_n)
  begin
    if (!retRst_n)
      calIv_reg <= ccr_pkg::CAL_RESET;
    else if (wrCalIv &&
             wrMask[0] && regPort.wrData[ccr_pkg::CAL_W-1:0] != 7'h00)
      calIv_reg <= regPort.wrData[ccr_pkg::CAL_W-1:0];
  end

  // Widest product, 127 units of 250 ms, still fits in 15 bits
  assign calPeriod_next = 15'(calIv_reg * ccr_pkg::CAL_UNIT_MS);

  // Period in milliseconds for the calibration timer, registered
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      calPeriod_reg <= 15'h0000;
    else
      calPeriod_reg <= calPeriod_next;
  end

  // Read mux; set and clear enable registers both show the enables
  always_comb
  begin
    rdValue = 32'h0000_0000;
    case (regPort.rdAddr)
      ccr_pkg::OFS_EVT_FAST:   rdValue[0] = evtFlag_reg[0];
      ccr_pkg::OFS_EVT_SLOW:   rdValue[0] = evtFlag_reg[1];
      ccr_pkg::OFS_EVT_DONE:   rdValue[0] = evtFlag_reg[2];
      ccr_pkg::OFS_EVT_TMO:    rdValue[0] = evtFlag_reg[3];
      ccr_pkg::OFS_IRQ_STATUS: rdValue[3:0] = evtFlag_reg;
      ccr_pkg::OFS_IRQ_SET,
      ccr_pkg::OFS_IRQ_CLR:    rdValue[3:0] = irqEn_reg;
      ccr_pkg::OFS_FAST_SEEN:  rdValue[0] = fastSeen_reg;
      ccr_pkg::OFS_FAST_STATE:
      begin
        rdValue[0]                    = fastXtalSync;
        rdValue[ccr_pkg::POS_RUNNING] = fastRunSync;
      end
      ccr_pkg::OFS_SLOW_SEEN:  rdValue[0] = slowSeen_reg;
      ccr_pkg::OFS_SLOW_STATE:
      begin
        rdValue[1:0]                  = srcSnap_reg;
        rdValue[ccr_pkg::POS_RUNNING] = slowRunSync;
      end
      ccr_pkg::OFS_SLOW_SNAP:  rdValue[1:0] = srcSnap_reg;
      ccr_pkg::OFS_SLOW_SEL:
      begin
        rdValue[1:0]                   = srcSel_reg;
        rdValue[ccr_pkg::POS_BYPASS]   = bypass_reg;
        rdValue[ccr_pkg::POS_EXTERNAL] = external_reg;
      end
      ccr_pkg::OFS_CAL_IV:     rdValue[6:0] = calIv_reg;
      default:                 rdValue = 32'h0000_0000;
    endcase
  end

  // Holes in the map answer with an error and read as zero
  assign rdHole         = !isMapped(regPort.rdAddr);
  // Read-only offsets accept writes silently; only holes report an error
  assign wrHole         = !isMapped(regPort.wrAddr);
  assign regPort.rdData = rdValue;
  assign regPort.rdErr  = rdHole;
  assign regPort.wrErr  = wrHole;

  assign slowSourceSel  = srcSel_reg;
  assign slowBypass     = bypass_reg;
  assign slowExternal   = external_reg;
  assign slowSourceSnap = srcSnap_reg;
  assign calInterval    = calIv_reg;
  assign calPeriodMs    = calPeriod_reg;
endmodule

// File: tb/ccr_assertions.sv
// Port checker for the clock control register block.
// Bound to ccr_top; watches its ports only, single sys_clk domain.
`timescale 1ns/100ps
module ccr_assertions
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        retRst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        fastStartedEvt,
  input wire logic        slowStartedEvt,
  input wire logic        calDoneEvt,
  input wire logic        calTimeoutEvt,
  input wire logic        slowStartTask,
  input wire logic [1:0]  slowSourceSel,
  input wire logic        slowBypass,
  input wire logic        slowExternal,
  input wire logic [1:0]  slowSourceSnap,
  input wire logic [6:0]  calInterval,
  input wire logic [14:0] calPeriodMs,
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic anyEvt;
  assign anyEvt = fastStartedEvt | slowStartedEvt | calDoneEvt | calTimeoutEvt;
  sequence s_wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_wrAnswer;
    ##2 bvalid;
  endsequence
  property p_wrAnswer;
    s_wrTaken |-> s_wrAnswer;
  endproperty
  property p_rdAnswer;
    arvalid && arready |=> rvalid;
  endproperty
  property p_bStand;
    bvalid && !bready |=> bvalid && !awready && !wready;
  endproperty
  property p_rStand;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  property p_snapCap;
    slowStartTask |=> slowSourceSnap == $past(slowSourceSel);
  endproperty
  property p_snapHold;
    !slowStartTask |=> $stable(slowSourceSnap);
  endproperty
  // Select outputs move only with a completed write
  property p_cfgWrite;
    $changed({slowSourceSel, slowBypass, slowExternal}) |-> bvalid;
  endproperty
  // Retained value has its own reset, so both resets disable
  property p_calWrite;
    disable iff (!rst_n || !retRst_n) $changed(calInterval) |-> bvalid && calInterval != 7'h00;
  endproperty
  property p_period;
    $past(rst_n) |-> calPeriodMs == 15'($past(calInterval) * 250);
  endproperty
  property p_irqRise;
    $rose(irq) |-> $past(anyEvt, 2) || $past(bvalid);
  endproperty
  property p_irqFall;
    $fell(irq) |-> $past(bvalid);
  endproperty
  a_wrAnswer: assert property (p_wrAnswer) else $error("write answer not on time");
  a_rdAnswer: assert property (p_rdAnswer) else $error("read answer not on time");
  a_bStand: assert property (p_bStand) else $error("write response dropped");
  a_rStand: assert property (p_rStand) else $error("read data dropped");
  a_snapCap: assert property (p_snapCap) else $error("snapshot not captured");
  a_snapHold: assert property (p_snapHold) else $error("snapshot not held");
  a_cfgWrite: assert property (p_cfgWrite) else $error("select moved without write");
  a_calWrite: assert property (p_calWrite) else $error("interval bad change");
  a_period: assert property (p_period) else $error("period not interval times unit");
  a_irqRise: assert property (p_irqRise) else $error("irq rose without cause");
  a_irqFall: assert property (p_irqFall) else $error("irq fell without write");
endmodule
bind ccr_top ccr_assertions i_ccr_assertions
(
  .sys_clk, .rst_n, .retRst_n, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rvalid, .rready, .fastStartedEvt, .slowStartedEvt, .calDoneEvt,
  .calTimeoutEvt, .slowStartTask, .slowSourceSel, .slowBypass, .slowExternal, .slowSourceSnap,
  .calInterval, .calPeriodMs, .irq
);

// File: tb/tb_top.sv
// Self-checking bench for the clock control register block.
// Drives AXI4-Lite, strobes and levels; a negedge monitor checks answers.
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        retRst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [5:0]  pl = 6'h00;
  logic [2:0]  lv = 3'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq, slowBypass, slowExternal;
  logic [1:0]  bresp, rresp, slowSourceSel, slowSourceSnap;
  logic [31:0] rdata;
  logic [6:0]  calInterval;
  logic [14:0] calPeriodMs;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [11:0] ofs[9] = '{12'h304, 12'h308, 12'h408, 12'h40c, 12'h414, 12'h418, 12'h41c, 12'h518, 12'h538};
  logic [11:0] evo[4] = '{12'h100, 12'h104, 12'h10c, 12'h110};
  int          error_cnt = 0;
  int          comparisons = 0;
  int          v;
  always #50 sys_clk = ~sys_clk;
  ccr_top i_ccr_top
  (
    .sys_clk, .rst_n, .retRst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .fastStartTask(pl[4]), .slowStartTask(pl[5]), .fastStartedEvt(pl[0]), .slowStartedEvt(pl[1]),
    .calDoneEvt(pl[2]), .calTimeoutEvt(pl[3]), .fastRunning(lv[0]), .fastXtalActive(lv[1]),
    .slowRunning(lv[2]), .slowSourceSel, .slowBypass, .slowExternal, .slowSourceSnap,
    .calInterval, .calPeriodMs, .irq
  );
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n > 40)
    begin
      error_cnt++;
      $display("mismatch at %0t: no bus answer", $time);
      give_verdict();
    end
  endtask
  // Handshakes judged at negedge: inputs only move at posedge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic ta, tw, vb, hb;
    int n;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b0;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      vb = bvalid;
      hb = bvalid & bready;
      @(posedge sys_clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      // Late ready keeps each response standing one stalled cycle
      if (vb && !hb)
        bready <= 1'b1;
      n++;
      tmo(n);
    end
    while (!hb);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic ta, vr, hr;
    int n;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b0;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      ta = arvalid & arready;
      vr = rvalid;
      hr = rvalid & rready;
      @(posedge sys_clk);
      if (ta)
        arvalid <= 1'b0;
      if (vr && !hr)
        rready <= 1'b1;
      n++;
      tmo(n);
    end
    while (!hr);
  endtask
  task automatic pulse(input int i);
    pl[i] <= 1'b1;
    @(posedge sys_clk);
    pl[i] <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic irqIs(input logic e);
    @(negedge sys_clk);
    chk(34'(irq), 34'(e));
    @(posedge sys_clk);
  endtask
  always @(negedge sys_clk)
  begin
    if (bvalid && bready)
      chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready)
      chk({rresp, rdata}, rq.pop_front());
  end
  initial
  begin
    void'($urandom(81));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    retRst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (ofs[k])
      rd(ofs[k], 32'h0);
    v = $urandom_range(15, 1);
    wr(12'h304, 32'(v));
    wr(12'h304, 32'h0);
    rd(12'h304, 32'(v));
    wr(12'h308, 32'h5);
    rd(12'h308, 32'(v & 10));
    wr(12'h304, 32'hf);
    for (int i = 0; i < 4; i++)
    begin
      pulse(i);
      irqIs(1'b1);
      rd(evo[i], 32'h1);
      wr(evo[i], 32'h0);
      rd(evo[i], 32'h0);
      irqIs(1'b0);
    end
    wr(12'h308, 32'h8);
    pulse(3);
    irqIs(1'b0);
    rd(12'h600, 32'h8);
    wr(12'h304, 32'h8);
    irqIs(1'b1);
    wr(12'h600, 32'h8);
    irqIs(1'b0);
    rd(12'h200, 32'h0, 2'h2);
    wr(12'h200, 32'h1, 2'h2);
    wr(12'h408, 32'h1);
    rd(12'h408, 32'h0);
    lv <= 3'h7;
    for (int s = 0; s < 3; s++)
    begin
      wr(12'h518, 32'(s));
      rd(12'h518, 32'(s));
      chk(34'(slowSourceSel), 34'(s));
    end
    wr(12'h518, 32'h0003_0001);
    chk(34'({slowExternal, slowBypass, slowSourceSel}), 34'hd);
    pulse(5);
    wr(12'h518, 32'h0);
    chk(34'({slowExternal, slowBypass, slowSourceSel}), 34'h0);
    chk(34'(slowSourceSnap), 34'h1);
    rd(12'h41c, 32'h1);
    rd(12'h414, 32'h1);
    rd(12'h418, 32'h0001_0001);
    rd(12'h408, 32'h0);
    pulse(4);
    rd(12'h408, 32'h1);
    rd(12'h40c, 32'h0001_0001);
    pulse(5);
    rd(12'h41c, 32'h0);
    v = $urandom_range(126, 1);
    wr(12'h538, 32'(v));
    wr(12'h538, 32'h0);
    rd(12'h538, 32'(v));
    chk(34'(calInterval), 34'(v));
    irqIs(1'b0);
    chk(34'(calPeriodMs), 34'(v * 250));
    wr(12'h538, 32'h7f);
    irqIs(1'b0);
    chk(34'(calPeriodMs), 34'(31750));
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(12'h538, 32'h7f);
    rd(12'h304, 32'h0);
    give_verdict();
  end
endmodule
